// ### vcw_pkg.sv
// Package of register map, field layout and reset values for the video crop window
package vcw_pkg;
  // ***********************************
  // Register byte offsets
  // ***********************************
  localparam logic [7:0] ADDR_LEFT_LOW = 8'h36;
  localparam logic [7:0] ADDR_LEFT_HIGH = 8'h37;
  localparam logic [7:0] ADDR_RIGHT_LOW = 8'h38;
  localparam logic [7:0] ADDR_RIGHT_HIGH = 8'h39;
  localparam logic [7:0] ADDR_TOP_LOW = 8'h3A;
  localparam logic [7:0] ADDR_TOP_HIGH = 8'h3B;
  localparam logic [7:0] ADDR_BOTTOM_LOW = 8'h3C;
  localparam logic [7:0] ADDR_BOTTOM_HIGH = 8'h3D;
  localparam logic [7:0] ADDR_PORT_SEL = 8'h3E;
  // ***********************************
  // Field layout and reset values
  // ***********************************
  localparam int COORD_W = 13;
  localparam int HIGH_W = 5;
  localparam int ENABLE_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [12:0] COORD_RESET = 13'h0000;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// ### vcw_window_port.sv
// One output port's crop window: coordinate store, position counters and gating
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
module vcw_window_port (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic wrEn,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdAddr,
  output logic [7:0] rdData,
  input wire logic inValid,
  input wire logic inFrameStart,
  input wire logic inLineStart,
  output logic passPixel,
  output logic cropOn
);
  // ***********************************
  // Coordinate registers
  // ***********************************
  logic enable_q;
  logic [12:0] left_q;
  logic [12:0] right_q;
  logic [12:0] top_q;
  logic [12:0] bottom_q;
  logic [12:0] pixelIdx_q;
  logic [12:0] lineIdx_q;
  logic lineSeen_q;
  logic [12:0] pixelNow;
  logic [12:0] lineNow;

  // Byte-wise writes into the 13-bit coordinates
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_q <= 1'b0;
      left_q <= vcw_pkg::COORD_RESET;
      right_q <= vcw_pkg::COORD_RESET;
      top_q <= vcw_pkg::COORD_RESET;
      bottom_q <= vcw_pkg::COORD_RESET;
    end else if (clk_en && wrEn) begin
      unique case (wrAddr)
        vcw_pkg::ADDR_LEFT_LOW: left_q[7:0] <= wrData;
        vcw_pkg::ADDR_LEFT_HIGH: begin
          left_q[12:8] <= wrData[4:0];
          enable_q <= wrData[vcw_pkg::ENABLE_BIT];
        end
        vcw_pkg::ADDR_RIGHT_LOW: right_q[7:0] <= wrData;
        vcw_pkg::ADDR_RIGHT_HIGH: right_q[12:8] <= wrData[4:0];
        vcw_pkg::ADDR_TOP_LOW: top_q[7:0] <= wrData;
        vcw_pkg::ADDR_TOP_HIGH: top_q[12:8] <= wrData[4:0];
        vcw_pkg::ADDR_BOTTOM_LOW: bottom_q[7:0] <= wrData;
        vcw_pkg::ADDR_BOTTOM_HIGH: bottom_q[12:8] <= wrData[4:0];
        default: ;
      endcase
    end
  end

  // Readback with reserved bits as zero
  always_comb begin
    unique case (rdAddr)
      vcw_pkg::ADDR_LEFT_LOW: rdData = left_q[7:0];
      vcw_pkg::ADDR_LEFT_HIGH: rdData = {enable_q, 2'b00, left_q[12:8]};
      vcw_pkg::ADDR_RIGHT_LOW: rdData = right_q[7:0];
      vcw_pkg::ADDR_RIGHT_HIGH: rdData = {3'b000, right_q[12:8]};
      vcw_pkg::ADDR_TOP_LOW: rdData = top_q[7:0];
      vcw_pkg::ADDR_TOP_HIGH: rdData = {3'b000, top_q[12:8]};
      vcw_pkg::ADDR_BOTTOM_LOW: rdData = bottom_q[7:0];
      vcw_pkg::ADDR_BOTTOM_HIGH: rdData = {3'b000, bottom_q[12:8]};
      default: rdData = vcw_pkg::UNMAPPED_READ;
    endcase
  end

  // ***********************************
  // Position of the current active pixel
  // ***********************************
  // Frame start resets line index, line start resets pixel index
  always_comb begin
    pixelNow = inLineStart ? 13'h0000 : pixelIdx_q;
    lineNow = inFrameStart ? 13'h0000 : (inLineStart && lineSeen_q ? lineIdx_q + 13'h0001 : lineIdx_q);
  end

  // Pixel counter advances only on active pixels; line counter at a line start after an active pixel
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pixelIdx_q <= vcw_pkg::COORD_RESET;
      lineIdx_q <= vcw_pkg::COORD_RESET;
      lineSeen_q <= 1'b0;
    end else if (clk_en) begin
      if (inFrameStart || inLineStart) begin
        lineIdx_q <= lineNow;
        lineSeen_q <= 1'b0;
        pixelIdx_q <= 13'h0000;
      end
      if (inValid) begin
        pixelIdx_q <= pixelNow + 13'h0001;
        lineIdx_q <= lineNow;
        lineSeen_q <= 1'b1;
      end
    end
  end

  // Window gate on the current pixel
  always_comb begin
    cropOn = enable_q;
    if (!enable_q) begin
      passPixel = inValid;
    end else begin
      passPixel = inValid && (pixelNow >= left_q)
        && (pixelNow <= right_q)
        && (lineNow >= top_q)
        && (lineNow <= bottom_q);
    end
  end
endmodule

// ### video_crop_window.sv
// Top of the per-port video crop window with register port and pixel path
`timescale 1ns/100ps
module video_crop_window #(
  parameter int PIXEL_W = 24,
  parameter int PORTS = 2
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic [PIXEL_W-1:0] pixelIn,
  input wire logic pixel_valid_in,
  input wire logic frameStart,
  input wire logic lineStart,
  output logic [PORTS-1:0][PIXEL_W-1:0] pixelOut,
  output logic [PORTS-1:0] pixel_valid,
  output logic [PORTS-1:0] cropActive
);
  // ***********************************
  // Port select and register port
  // ***********************************
  logic [7:0] portSel_q;
  logic [7:0] rdData_q;
  logic [PORTS-1:0] portWr;
  logic [PORTS-1:0] portPass;
  logic [7:0] portRd [PORTS];
  logic [7:0] selRd;
  logic selValid;

  // Selected port register, held as the full written byte
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      portSel_q <= vcw_pkg::REG_RESET;
    end else if (clk_en && regWrite && regAddr == vcw_pkg::ADDR_PORT_SEL) begin
      portSel_q <= regWrData;
    end
  end

  assign selValid = (portSel_q < 8'(PORTS));

  // Write strobe steered to the selected port
  always_comb begin
    for (int i = 0; i < PORTS; i++) begin
      portWr[i] = regWrite && selValid && (portSel_q == 8'(i));
    end
  end

  // Read mux from the selected port
  always_comb begin
    selRd = vcw_pkg::UNMAPPED_READ;
    for (int i = 0; i < PORTS; i++) begin
      if (selValid && portSel_q == 8'(i)) begin
        selRd = portRd[i];
      end
    end
    if (regAddr == vcw_pkg::ADDR_PORT_SEL) begin
      selRd = portSel_q;
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= vcw_pkg::REG_RESET;
    end else if (clk_en) begin
      rdData_q <= regRead ? selRd : vcw_pkg::REG_RESET;
    end
  end

  assign regRdData = rdData_q;

  // ***********************************
  // Per-port windows
  // ***********************************
  for (genvar p = 0; p < PORTS; p++) begin : gPort
    vcw_window_port uWin (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .wrEn(portWr[p]),
      .wrAddr(regAddr),
      .wrData(regWrData),
      .rdAddr(regAddr),
      .rdData(portRd[p]),
      .inValid(pixel_valid_in),
      .inFrameStart(frameStart),
      .inLineStart(lineStart),
      .passPixel(portPass[p]),
      .cropOn(cropActive[p])
    );
  end

  // ***********************************
  // Output pixel registers
  // ***********************************
  // Blanked pixels drop the valid flag and zero the data
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pixelOut <= '0;
      pixel_valid <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < PORTS; i++) begin
        pixel_valid[i] <= portPass[i];
        pixelOut[i] <= portPass[i] ? pixelIn : '0;
      end
    end
  end
endmodule

// ### vcw_sva.sv
// Port checker for the crop window
`timescale 1ns/100ps
module vcw_sva #(parameter int PIXEL_W = 24, parameter int PORTS = 2) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic [PIXEL_W-1:0] pixelIn,
  input wire logic pixel_valid_in,
  input wire logic [PORTS-1:0][PIXEL_W-1:0] pixelOut,
  input wire logic [PORTS-1:0] pixel_valid,
  input wire logic [PORTS-1:0] cropActive
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Register port and pixel path relations
  chk_rd_after_read: assert property (regRdData != 8'h00 |-> $past(regRead)) else $error("stray rd");
  chk_unmapped_rd: assert property (regRead && regAddr > 8'h3E |=> regRdData == 8'h00) else $error("unmapped");
  chk_blank_zero0: assert property (!pixel_valid[0] |-> pixelOut[0] == '0) else $error("blank 0");
  chk_blank_zero1: assert property (!pixel_valid[1] |-> pixelOut[1] == '0) else $error("blank 1");
  chk_valid_cause: assert property (pixel_valid[0] |-> $past(pixel_valid_in)) else $error("no cause");
  chk_pass_data: assert property (pixel_valid[1] |-> pixelOut[1] == $past(pixelIn)) else $error("data");
  chk_nocrop_pass0: assert property (pixel_valid_in && !cropActive[0] |=> pixel_valid[0]) else $error("drop");
  chk_nocrop_pass1: assert property (pixel_valid_in && !cropActive[1] ##1 1 |-> pixel_valid[1]) else $error("drop");
endmodule
bind video_crop_window vcw_sva #(.PIXEL_W(PIXEL_W), .PORTS(PORTS)) i_sva (.ref_clk, .arst_n, .regAddr,
  .regRead, .regRdData, .pixelIn, .pixel_valid_in, .pixelOut, .pixel_valid, .cropActive);

// ### vcw_src.sv
// Raster source standing in for the host pixel stream
`timescale 1ns/100ps
module vcw_src #(parameter int W = 6, parameter int H = 5) (
  input wire logic ref_clk,
  input wire logic arst_n,
  output logic [23:0] pixelIn,
  output logic pixValid,
  output logic frameStart,
  output logic lineStart
);
  logic [7:0] x, y;
  // W active pixels then one blank cycle per line
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      x <= 8'h00;
      y <= 8'h00;
    end else if (x == 8'(W)) begin
      x <= 8'h00;
      y <= (y == 8'(H - 1)) ? 8'h00 : y + 8'h01;
    end else begin
      x <= x + 8'h01;
    end
  end
  // Origin pulses ride on the first active pixel; idle data inverted
  assign pixValid = x < 8'(W);
  assign lineStart = x == 8'h00;
  assign frameStart = lineStart && y == 8'h00;
  assign pixelIn = pixValid ? {8'hA5, y, x} : ~{8'hA5, y, x};
endmodule

// ### video_crop_window_tb.sv
// Random and corner crop windows over a fixed raster
`timescale 1ns/100ps
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin errCount++; $display("ERROR %0t bad %h", $time, a); end end
module video_crop_window_tb;
  localparam int W = 6, H = 5;
  logic ref_clk = 1'b0, arst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, run = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic [23:0] pixelIn, expD;
  logic pixValid, frameStart, lineStart, ce[2];
  logic [1:0][23:0] pixelOut;
  logic [1:0] pixelValid, cropOn, expV;
  logic [12:0] c[2][4];
  int errCount = 0, totalChecks = 0;
  vcw_src #(.W(W), .H(H)) i_src (.ref_clk, .arst_n, .pixelIn, .pixValid, .frameStart, .lineStart);
  video_crop_window i_dut (.ref_clk, .arst_n, .clk_en(1'b1), .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .pixelIn, .pixel_valid_in(pixValid), .frameStart, .lineStart, .pixelOut,
    .pixel_valid(pixelValid), .cropActive(cropOn));
  initial forever #10 ref_clk = ~ref_clk;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 `CHK(regRdData, e)
    @(posedge ref_clk);
  endtask
  // Writes (reserved bits set) or reads back one port's window
  task automatic regs(input int p, input bit isRd);
    logic [7:0] v;
    wr(vcw_pkg::ADDR_PORT_SEL, 8'(p));
    for (int i = 0; i < 8; i++) begin
      v = i[0] ? {i == 1 ? ce[p] : ~isRd, {2{~isRd}}, c[p][i/2][12:8]} : c[p][i/2][7:0];
      if (isRd) rd(vcw_pkg::ADDR_LEFT_LOW + 8'(i), v);
      else wr(vcw_pkg::ADDR_LEFT_LOW + 8'(i), v);
    end
  endtask
  // Output model one cycle behind the input raster
  always @(negedge ref_clk) begin
    for (int p = 0; p < 2; p++) begin
      if (run) begin
        `CHK(pixelValid[p], expV[p])
        `CHK(pixelOut[p], expV[p] ? expD : 24'h000000)
        `CHK(cropOn[p], ce[p])
      end
      expV[p] = pixValid && (!ce[p] || (pixelIn[7:0] >= c[p][0] && pixelIn[7:0] <= c[p][1]
        && pixelIn[15:8] >= c[p][2] && pixelIn[15:8] <= c[p][3]));
    end
    expD = pixelIn;
  end
  initial begin
    void'($urandom(32'hA26C1788));
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 9; i++) rd(vcw_pkg::ADDR_LEFT_LOW + 8'(i), 8'h00);
    rd(8'h50, vcw_pkg::UNMAPPED_READ);
    for (int k = 0; k < 6; k++) begin
      run = 1'b0;
      for (int p = 0; p < 2; p++) begin
        ce[p] = (k > 0) && 1'($urandom);
        for (int i = 0; i < 4; i++) c[p][i] = 13'($urandom_range(0, 7)) | (k == 5 ? {5'($urandom), 8'h00} : 13'h0000);
      end
      if (k == 1) begin
        ce[0] = 1'b1;
        c[0] = '{13'h0000, 13'(W - 1), 13'h0000, 13'(H - 1)};
      end
      for (int p = 0; p < 4; p++) regs(p % 2, p > 1);
      @(posedge ref_clk);
      run = 1'b1;
      repeat (2 * H * (W + 1)) @(posedge ref_clk);
    end
    // Out-of-range port select: coordinate writes dropped, reads zero
    run = 1'b0;
    wr(vcw_pkg::ADDR_PORT_SEL, 8'h02);
    wr(vcw_pkg::ADDR_TOP_LOW, 8'hFF);
    rd(vcw_pkg::ADDR_TOP_LOW, vcw_pkg::UNMAPPED_READ);
    rd(vcw_pkg::ADDR_PORT_SEL, 8'h02);
    for (int p = 0; p < 2; p++) regs(p, 1'b1);
    endSim;
  end
  initial begin
    #100us;
    errCount++;
    endSim;
  end
  task automatic endSim;
    if (errCount == 0 && totalChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
endmodule
